// ===== bench/tam_host.sv
// Register host model on the strobe port
`timescale 1ns/1ps
module tam_host (
   input wire logic i_mclk,
   input wire logic [7:0] i_rd_data,
   output logic [7:0] o_cmd_addr,
   output logic o_wr_en,
   output logic [7:0] o_wr_data,
   output logic o_rd_en
);
   initial {o_cmd_addr, o_wr_en, o_wr_data, o_rd_en} = '0;
   // Idle address and data inverted, strobes cleared, so stale values never pass
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(negedge i_mclk);
      {o_cmd_addr, o_wr_data, o_wr_en, o_rd_en} = {a, d, w, !w};
      @(negedge i_mclk);
      {o_cmd_addr, o_wr_data, o_wr_en, o_rd_en} = {~a, ~d, 2'b00};
      q = i_rd_data;
   endtask
endmodule

// ===== bench/thermal_alarm_limit_mask_regs_assertions.sv
// Port checks for the thermal alarm register bank
`timescale 1ns/1ps
module thermal_alarm_limit_mask_regs_assertions #(
   parameter logic [7:0] MAKER_CODE = 8'h5A
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_rd_en,
   input wire logic [7:0] i_cmd_addr,
   input wire logic [7:0] i_local_temp,
   input wire logic [7:0] o_rd_data,
   input wire logic o_rd_valid,
   input wire logic o_first_alarm_output,
   input wire logic o_second_alarm_output,
   input wire logic o_third_alarm_output
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   property p_rd; i_rd_en |=> o_rd_valid; endproperty
   a_rd: assert property (p_rd) else $error("read unanswered");
   property p_nord; !i_rd_en |=> !o_rd_valid; endproperty
   a_nord: assert property (p_nord) else $error("stray read valid");
   property p_msk; o_rd_valid && $past(i_cmd_addr) == 8'h0E |-> o_rd_data[7:3] == 5'h00; endproperty
   a_msk: assert property (p_msk) else $error("mask top bits set");
   property p_lim; o_rd_valid && $past(i_cmd_addr) == 8'h40 |-> !o_rd_data[7]; endproperty
   a_lim: assert property (p_lim) else $error("limit bit 7 set");
   property p_hys; o_rd_valid && $past(i_cmd_addr) == 8'h5A |-> o_rd_data[7:5] == 3'h0; endproperty
   a_hys: assert property (p_hys) else $error("hysteresis top bits set");
   property p_id; o_rd_valid && $past(i_cmd_addr) == 8'hFE |-> o_rd_data == MAKER_CODE; endproperty
   a_id: assert property (p_id) else $error("maker code changed");
   property p_sub; o_third_alarm_output |-> o_second_alarm_output; endproperty
   a_sub: assert property (p_sub) else $error("third alarm without second");
   property p_loc; i_local_temp[7] [*3] |=> o_first_alarm_output && o_second_alarm_output; endproperty
   a_loc: assert property (p_loc) else $error("local alarm missing");
endmodule
bind thermal_alarm_limit_mask_regs thermal_alarm_limit_mask_regs_assertions #(.MAKER_CODE(MAKER_CODE))
   u_thermal_alarm_limit_mask_regs_assertions (.*);

// ===== bench/thermal_alarm_limit_mask_regs_bench.sv
// Self-checking bench for the thermal alarm register bank
`timescale 1ns/1ps
module thermal_alarm_limit_mask_regs_bench;
   import thermal_alarm_pkg::*;
   logic i_mclk = 1'b0, i_rst_n = 1'b0, i_wr_en, i_rd_en, o_rd_valid;
   logic o_first_alarm_output, o_second_alarm_output, o_third_alarm_output;
   reg_byte_t i_cmd_addr, i_wr_data, o_rd_data, i_local_temp, i_remote1_temp, i_remote2_temp, got;
   int err_total = 0, comparisons = 0;
   always #4 i_mclk = ~i_mclk;
   tam_host u_tam_host (.i_mclk, .i_rd_data(o_rd_data), .o_cmd_addr(i_cmd_addr), .o_wr_en(i_wr_en),
      .o_wr_data(i_wr_data), .o_rd_en(i_rd_en));
   thermal_alarm_limit_mask_regs u_thermal_alarm_limit_mask_regs (.*);
   task automatic chk(input logic [7:0] s, e, input string n);
      comparisons++;
      if (s !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input reg_byte_t a, d);
      u_tam_host.xfer(1'b1, a, d, got);
   endtask
   task automatic rd(input reg_byte_t a, e);
      u_tam_host.xfer(1'b0, a, 8'h00, got);
      chk(got, e, "register");
   endtask
   // Four cycles covers the two-cycle alarm latency with margin
   task automatic al(input logic [23:0] t, input logic [2:0] e);
      {i_local_temp, i_remote1_temp, i_remote2_temp} = t;
      repeat (4) @(negedge i_mclk);
      chk({5'h00, o_first_alarm_output, o_second_alarm_output, o_third_alarm_output}, {5'h00, e}, "alarms");
   endtask
   task automatic t_regs;
      rd(8'h0E, 8'h07);
      rd(8'hFF, 8'h3C);
      wr(8'h0E, 8'hFD);
      wr(8'h40, 8'hFF);
      wr(8'h41, 8'hFF);
      wr(8'h49, 8'h30);
      wr(8'h5A, 8'hE2);
      wr(8'hFE, 8'h00);
      rd(8'h0E, 8'h05);
      rd(8'h40, 8'h7F);
      rd(8'h41, 8'hFF);
      rd(8'h5A, 8'h02);
      rd(8'hFE, 8'h5A);
      rd(8'h10, 8'h00);
   endtask
   task automatic t_alarm;
      al(24'h00_3000, 3'b011);
      al(24'h00_2E00, 3'b011);
      al(24'h00_2D00, 3'b000);
      wr(8'h0E, 8'h07);
      al(24'h00_3000, 3'b010);
      al(24'h80_3000, 3'b110);
      al(24'h00_006E, 3'b110);
      wr(8'h0E, 8'h00);
      al(24'h00_006E, 3'b111);
   endtask
   task automatic finish_test;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      {i_local_temp, i_remote1_temp, i_remote2_temp} = '0;
      repeat (20) @(negedge i_mclk);
      i_rst_n = 1'b1;
      t_regs();
      t_alarm();
      finish_test();
   end
   initial begin
      #20000;
      err_total++;
      finish_test();
   end
endmodule

// ===== core/thermal_alarm_limit_mask_regs.sv
// Alarm limit, hysteresis, mask and identification registers with alarm evaluation
`timescale 1ns/1ps
`include "thermal_alarm_map.svh"
module thermal_alarm_limit_mask_regs
   import thermal_alarm_pkg::*;
#(
   parameter int DATA_W = 8,
   parameter logic [7:0] MAKER_CODE = 8'h5A,    // Arbitrary value
   parameter logic [7:0] REVISION_CODE = 8'h3C  // Arbitrary value
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_cmd_addr,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_data,
   input wire logic i_rd_en,
   input wire logic [DATA_W-1:0] i_local_temp,
   input wire logic [DATA_W-1:0] i_remote1_temp,
   input wire logic [DATA_W-1:0] i_remote2_temp,
   output logic [7:0] o_rd_data,
   output logic o_rd_valid,
   output logic o_first_alarm_output,
   output logic o_second_alarm_output,
   output logic o_third_alarm_output
);

   if (DATA_W != 8) begin
      $error("DATA_W must be 8: limits are whole-degree bytes");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   event_mask_t alarm3_mask_q;
   local_limit_t local_limit_q;
   reg_byte_t r1_first_q;
   reg_byte_t r2_first_q;
   reg_byte_t r1_second_q;
   reg_byte_t r2_second_q;
   hyst_t hyst_q;

   // Only writable bits are stored; ID and read-only bits have no storage
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         alarm3_mask_q <= `RST_ALARM3_EVENT_MASK;
         local_limit_q <= `RST_LOCAL_ALARM_LIMIT;
         r1_first_q <= `RST_REMOTE_FIRST_LIMIT;
         r2_first_q <= `RST_REMOTE_FIRST_LIMIT;
         r1_second_q <= `RST_REMOTE_SECOND_LIMIT;
         r2_second_q <= `RST_REMOTE_SECOND_LIMIT;
         hyst_q <= `RST_SHARED_ALARM_HYSTERESIS;
      end else if (i_wr_en) begin
         case (i_cmd_addr)
            `ADDR_ALARM3_EVENT_MASK: alarm3_mask_q <= i_wr_data[2:0];
            `ADDR_LOCAL_ALARM_LIMIT: local_limit_q <= i_wr_data[6:0];
            `ADDR_REMOTE1_FIRST_LIMIT: r1_first_q <= i_wr_data;
            `ADDR_REMOTE2_FIRST_LIMIT: r2_first_q <= i_wr_data;
            `ADDR_REMOTE1_SECOND_LIMIT: r1_second_q <= i_wr_data;
            `ADDR_REMOTE2_SECOND_LIMIT: r2_second_q <= i_wr_data;
            `ADDR_SHARED_ALARM_HYSTERESIS: hyst_q <= i_wr_data[4:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port

   reg_byte_t rd_data_d;

   always_comb begin
      case (i_cmd_addr)
         `ADDR_ALARM3_EVENT_MASK: rd_data_d = {5'h00, alarm3_mask_q};
         `ADDR_LOCAL_ALARM_LIMIT: rd_data_d = {1'b0, local_limit_q};
         `ADDR_REMOTE1_FIRST_LIMIT: rd_data_d = r1_first_q;
         `ADDR_REMOTE2_FIRST_LIMIT: rd_data_d = r2_first_q;
         `ADDR_REMOTE1_SECOND_LIMIT: rd_data_d = r1_second_q;
         `ADDR_REMOTE2_SECOND_LIMIT: rd_data_d = r2_second_q;
         `ADDR_SHARED_ALARM_HYSTERESIS: rd_data_d = {3'h0, hyst_q};
         `ADDR_MAKER_CODE: rd_data_d = MAKER_CODE;
         `ADDR_REVISION_CODE: rd_data_d = REVISION_CODE;
         default: rd_data_d = 8'h00;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rd_data <= 8'h00;
         o_rd_valid <= 1'b0;
      end else begin
         o_rd_valid <= i_rd_en;
         if (i_rd_en) begin
            o_rd_data <= rd_data_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error status with hysteresis

   // temp < limit - hyst rewritten as temp + hyst < limit, so no underflow
   function automatic logic next_status(input logic cur, input reg_byte_t temp,
                                        input reg_byte_t lim, input hyst_t hyst);
      logic [8:0] low_sum;
      low_sum = {1'b0, temp} + {4'h0, hyst};
      if (temp >= lim) begin
         next_status = 1'b1;
      end else if (low_sum < {1'b0, lim}) begin
         next_status = 1'b0;
      end else begin
         next_status = cur;
      end
   endfunction

   logic local_err_q;
   logic r1_first_err_q;
   logic r2_first_err_q;
   logic r1_second_err_q;
   logic r2_second_err_q;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         local_err_q <= 1'b0;
         r1_first_err_q <= 1'b0;
         r2_first_err_q <= 1'b0;
         r1_second_err_q <= 1'b0;
         r2_second_err_q <= 1'b0;
      end else begin
         local_err_q <= next_status(local_err_q, i_local_temp, {1'b0, local_limit_q}, hyst_q);
         r1_first_err_q <= next_status(r1_first_err_q, i_remote1_temp, r1_first_q, hyst_q);
         r2_first_err_q <= next_status(r2_first_err_q, i_remote2_temp, r2_first_q, hyst_q);
         r1_second_err_q <= next_status(r1_second_err_q, i_remote1_temp, r1_second_q, hyst_q);
         r2_second_err_q <= next_status(r2_second_err_q, i_remote2_temp, r2_second_q, hyst_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alarm outputs, registered for glitch-free pins

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_first_alarm_output <= 1'b0;
         o_second_alarm_output <= 1'b0;
         o_third_alarm_output <= 1'b0;
      end else begin
         o_first_alarm_output <= local_err_q | r1_first_err_q | r2_first_err_q;
         o_second_alarm_output <= local_err_q | r1_second_err_q | r2_second_err_q;
         o_third_alarm_output <=
            (local_err_q & ~alarm3_mask_q[`MASK_LOCAL_EVENT_BLOCK]) |
            (r1_second_err_q & ~alarm3_mask_q[`MASK_REMOTE1_EVENT_BLOCK]) |
            (r2_second_err_q & ~alarm3_mask_q[`MASK_REMOTE2_EVENT_BLOCK]);
      end
   end

endmodule

// ===== core/thermal_alarm_map.svh
// Register offsets, reset values and field positions of the thermal alarm register bank
`ifndef THERMAL_ALARM_MAP_SVH
`define THERMAL_ALARM_MAP_SVH

`define ADDR_ALARM3_EVENT_MASK 8'h0E
`define ADDR_LOCAL_ALARM_LIMIT 8'h40
`define ADDR_REMOTE1_FIRST_LIMIT 8'h41
`define ADDR_REMOTE2_FIRST_LIMIT 8'h42
`define ADDR_REMOTE1_SECOND_LIMIT 8'h49
`define ADDR_REMOTE2_SECOND_LIMIT 8'h4A
`define ADDR_SHARED_ALARM_HYSTERESIS 8'h5A
`define ADDR_MAKER_CODE 8'hFE
`define ADDR_REVISION_CODE 8'hFF

`define RST_ALARM3_EVENT_MASK 3'h7
`define RST_LOCAL_ALARM_LIMIT 7'h55
`define RST_REMOTE_FIRST_LIMIT 8'h6E
`define RST_REMOTE_SECOND_LIMIT 8'h55
`define RST_SHARED_ALARM_HYSTERESIS 5'h0A

`define MASK_LOCAL_EVENT_BLOCK 0
`define MASK_REMOTE1_EVENT_BLOCK 1
`define MASK_REMOTE2_EVENT_BLOCK 2

`endif

// ===== core/thermal_alarm_pkg.sv
// Types shared by the thermal alarm register bank
package thermal_alarm_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef logic [6:0] local_limit_t;
   typedef logic [4:0] hyst_t;
   typedef logic [2:0] event_mask_t;
endpackage
